/* pkg/hpcr_pkg.sv */
/*
 * Constants for the host port control register block: CPU-side register
 * offsets, field positions and reset values of the control and emulation
 * registers.
 * Assumes a single 250 MHz device clock and a synchronous active-high reset.
 */
package hpcr_pkg;
    localparam logic [5:0] OFF_POWER_EMU = 6'h04;
    localparam logic [5:0] OFF_PORT_CTRL = 6'h30;
    localparam logic [5:0] OFF_WR_ADDR = 6'h34;
    localparam logic [5:0] OFF_RD_ADDR = 6'h38;

    localparam int BIT_FREE_RUN = 0;
    localparam int BIT_SOFT_HALT = 1;

    localparam int BIT_ADDR_SEL = 11;
    localparam int BIT_RSVD10 = 10;
    localparam int BIT_SPLIT_MODE = 9;
    localparam int BIT_HW_ORDER_STAT = 8;
    localparam int BIT_SOFT_RESET = 7;
    localparam int BIT_FETCH = 4;
    localparam int BIT_RSVD_ONE = 3;
    localparam int BIT_TO_HOST_INT = 2;
    localparam int BIT_TO_CPU_INT = 1;
    localparam int BIT_HW_ORDER = 0;

    localparam logic RST_FREE_RUN = 1'b0;
    localparam logic RST_SOFT_HALT = 1'b0;
    localparam logic RST_CTRL_BIT = 1'b0;
    localparam logic RSVD_ONE_VAL = 1'b1;
    localparam logic [31:0] RST_ADDR = 32'h0000_0000;
endpackage

/* hdl/hpcr_addr_route.sv */
/*
 * Write and read address register pair with host routing.
 * Assumes host halfword accesses and CPU word accesses on sys_clk; the
 * control register supplies mode, select and halfword order.
 */
`timescale 1ns/1ns
module hpcr_addr_route #(
    parameter int AW = 32
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic splitMode,
    input wire logic addrSelect,
    input wire logic halfwordOrder,
    input wire logic hostAddrWr,
    input wire logic hostAddrRd,
    input wire logic hostSecondHalf,
    input wire logic [AW/2-1:0] hostWdata,
    output logic [AW/2-1:0] hostAddrRdata,
    input wire logic cpuWrAddrWe,
    input wire logic cpuRdAddrWe,
    input wire logic [AW-1:0] cpuWdata,
    output logic [AW-1:0] writeAddr,
    output logic [AW-1:0] readAddr
);
    logic hostToWrite;
    logic hostToRead;
    logic upperHalf;
    logic [AW-1:0] hostSrc;

    // without split mode host writes move both registers together as one
    assign hostToWrite = splitMode ? ~addrSelect : 1'b1;
    assign hostToRead = splitMode ? addrSelect : 1'b1;
    // order 0 sends the upper half first
    assign upperHalf = hostSecondHalf ~^ halfwordOrder;
    assign hostSrc = (splitMode && !addrSelect) ? writeAddr : readAddr;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            writeAddr <= hpcr_pkg::RST_ADDR;
        end else if (hostAddrWr && hostToWrite) begin
            if (upperHalf) begin
                writeAddr[AW-1:AW/2] <= hostWdata;
            end else begin
                writeAddr[AW/2-1:0] <= hostWdata;
            end
        end else if (cpuWrAddrWe) begin
            writeAddr <= cpuWdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            readAddr <= hpcr_pkg::RST_ADDR;
        end else if (hostAddrWr && hostToRead) begin
            if (upperHalf) begin
                readAddr[AW-1:AW/2] <= hostWdata;
            end else begin
                readAddr[AW/2-1:0] <= hostWdata;
            end
        end else if (cpuRdAddrWe) begin
            readAddr <= cpuWdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hostAddrRdata <= '0;
        end else if (hostAddrRd) begin
            hostAddrRdata <= upperHalf ? hostSrc[AW-1:AW/2] : hostSrc[AW/2-1:0];
        end
    end
endmodule

/* hdl/hpcr_regs.sv */
/*
 * Host port control and emulation-management registers.
 * Assumes the host strobe decoder hands over one-cycle requests on sys_clk,
 * the CPU reaches its registers by offset, and boot and suspend levels are
 * produced by on-chip logic on the same clock.
 * The halt is only reported; the port sequencers must act on it.
 */
`timescale 1ns/1ns
module hpcr_regs #(
    parameter int AW = 32
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic bootViaPort,
    input wire logic cpuWe,
    input wire logic cpuRe,
    input wire logic [5:0] cpuAddr,
    input wire logic [31:0] cpuWdata,
    output logic [31:0] cpuRdata,
    input wire logic hostCtrlWr,
    input wire logic hostCtrlRd,
    input wire logic [15:0] hostCtrlWdata,
    output logic [15:0] hostCtrlRdata,
    input wire logic hostAddrWr,
    input wire logic hostAddrRd,
    input wire logic hostSecondHalf,
    input wire logic [AW/2-1:0] hostAddrWdata,
    output logic [AW/2-1:0] hostAddrRdata,
    output logic [AW-1:0] writeAddr,
    output logic [AW-1:0] readAddr,
    input wire logic emuSuspend,
    input wire logic xferBusy,
    output logic portHalted,
    output logic portSoftReset,
    output logic fetchRequest,
    output logic cpuIntPulse,
    output logic hostIntN,
    output logic halfwordOrder
);
    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic freeRun_r;
    logic softHalt_r;
    logic addrSelect_r;
    logic rsvd10_r;
    logic splitMode_r;
    logic hwOrderStat_r;
    logic softReset_r;
    logic [1:0] rsvd65_r;
    logic toHostInt_r;
    logic toCpuInt_r;
    logic hwOrder_r;
    logic halted_r;
    logic fetch_r;
    logic cpuInt_r;

    logic cpuCtrlWe;
    logic cpuPowerWe;
    logic cpuWrAddrWe;
    logic cpuRdAddrWe;
    logic hostSetsCpuInt;
    logic hostClearsHostInt;
    logic cpuSetsHostInt;
    logic cpuClearsCpuInt;
    logic haltWanted;
    logic [15:0] ctrlView;
    logic [31:0] powerView;
    logic [31:0] cpuReadMux;

    // ----------------------------------------------------------------
    // CPU access decode
    // ----------------------------------------------------------------
    assign cpuCtrlWe = cpuWe && (cpuAddr == hpcr_pkg::OFF_PORT_CTRL);
    assign cpuPowerWe = cpuWe && (cpuAddr == hpcr_pkg::OFF_POWER_EMU);
    assign cpuWrAddrWe = cpuWe && (cpuAddr == hpcr_pkg::OFF_WR_ADDR);
    assign cpuRdAddrWe = cpuWe && (cpuAddr == hpcr_pkg::OFF_RD_ADDR);

    // ----------------------------------------------------------------
    // write events
    // ----------------------------------------------------------------
    // each side only acts on a one in the interrupt bits
    assign hostSetsCpuInt = hostCtrlWr && hostCtrlWdata[hpcr_pkg::BIT_TO_CPU_INT];
    assign hostClearsHostInt = hostCtrlWr && hostCtrlWdata[hpcr_pkg::BIT_TO_HOST_INT];
    assign cpuSetsHostInt = cpuCtrlWe && cpuWdata[hpcr_pkg::BIT_TO_HOST_INT];
    assign cpuClearsCpuInt = cpuCtrlWe && cpuWdata[hpcr_pkg::BIT_TO_CPU_INT];
    // suspend only matters with free-run clear and soft halt set
    assign haltWanted = emuSuspend && !freeRun_r && softHalt_r;

    // ----------------------------------------------------------------
    // emulation management
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            freeRun_r <= hpcr_pkg::RST_FREE_RUN;
            softHalt_r <= hpcr_pkg::RST_SOFT_HALT;
        end else if (cpuPowerWe) begin
            freeRun_r <= cpuWdata[hpcr_pkg::BIT_FREE_RUN];
            softHalt_r <= cpuWdata[hpcr_pkg::BIT_SOFT_HALT];
        end
    end

    // halt only once the running transaction is done; release on resume
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            halted_r <= 1'b0;
        end else if (!haltWanted) begin
            halted_r <= 1'b0;
        end else if (!xferBusy) begin
            halted_r <= 1'b1;
        end
    end

    assign portHalted = halted_r;

    // ----------------------------------------------------------------
    // control register fields owned by the host
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            addrSelect_r <= hpcr_pkg::RST_CTRL_BIT;
            rsvd10_r <= hpcr_pkg::RST_CTRL_BIT;
            splitMode_r <= hpcr_pkg::RST_CTRL_BIT;
            rsvd65_r <= '0;
            hwOrder_r <= hpcr_pkg::RST_CTRL_BIT;
            hwOrderStat_r <= hpcr_pkg::RST_CTRL_BIT;
        end else if (hostCtrlWr) begin
            addrSelect_r <= hostCtrlWdata[hpcr_pkg::BIT_ADDR_SEL];
            rsvd10_r <= hostCtrlWdata[hpcr_pkg::BIT_RSVD10];
            splitMode_r <= hostCtrlWdata[hpcr_pkg::BIT_SPLIT_MODE];
            rsvd65_r <= hostCtrlWdata[6:5];
            hwOrder_r <= hostCtrlWdata[hpcr_pkg::BIT_HW_ORDER];
            hwOrderStat_r <= hostCtrlWdata[hpcr_pkg::BIT_HW_ORDER];
        end
    end

    assign halfwordOrder = hwOrder_r;

    // ----------------------------------------------------------------
    // software reset: boot-dependent reset value, both sides may set
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            softReset_r <= ~bootViaPort;
        end else if (hostCtrlWr) begin
            // the host write carries the whole bit and beats a CPU write
            softReset_r <= hostCtrlWdata[hpcr_pkg::BIT_SOFT_RESET];
        end else if (cpuCtrlWe && cpuWdata[hpcr_pkg::BIT_SOFT_RESET]) begin
            softReset_r <= 1'b1;
        end else if (cpuCtrlWe && !cpuWdata[hpcr_pkg::BIT_SOFT_RESET]) begin
            softReset_r <= 1'b0;
        end
    end

    assign portSoftReset = softReset_r;

    // ----------------------------------------------------------------
    // prefetch request: host write of one, never stored
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fetch_r <= 1'b0;
        end else begin
            fetch_r <= hostCtrlWr && hostCtrlWdata[hpcr_pkg::BIT_FETCH];
        end
    end

    assign fetchRequest = fetch_r;

    // ----------------------------------------------------------------
    // interrupt toward the host: CPU sets, host clears
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            toHostInt_r <= 1'b0;
        end else if (cpuSetsHostInt) begin
            // a set in the same cycle as the clear wins, so no request is lost
            toHostInt_r <= 1'b1;
        end else if (hostClearsHostInt) begin
            toHostInt_r <= 1'b0;
        end
    end

    assign hostIntN = ~toHostInt_r;

    // ----------------------------------------------------------------
    // interrupt toward the CPU: host sets, CPU acknowledges
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            toCpuInt_r <= 1'b0;
        end else if (hostSetsCpuInt) begin
            toCpuInt_r <= 1'b1;
        end else if (cpuClearsCpuInt) begin
            toCpuInt_r <= 1'b0;
        end
    end

    // pulse only on a rising edge: no new interrupt while still pending
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cpuInt_r <= 1'b0;
        end else begin
            cpuInt_r <= hostSetsCpuInt && !toCpuInt_r;
        end
    end

    assign cpuIntPulse = cpuInt_r;

    // ----------------------------------------------------------------
    // read views
    // ----------------------------------------------------------------
    always_comb begin
        ctrlView = '0;
        ctrlView[hpcr_pkg::BIT_ADDR_SEL] = addrSelect_r;
        ctrlView[hpcr_pkg::BIT_RSVD10] = rsvd10_r;
        ctrlView[hpcr_pkg::BIT_SPLIT_MODE] = splitMode_r;
        ctrlView[hpcr_pkg::BIT_HW_ORDER_STAT] = hwOrderStat_r;
        ctrlView[hpcr_pkg::BIT_SOFT_RESET] = softReset_r;
        ctrlView[6:5] = rsvd65_r;
        ctrlView[hpcr_pkg::BIT_FETCH] = 1'b0;
        ctrlView[hpcr_pkg::BIT_RSVD_ONE] = hpcr_pkg::RSVD_ONE_VAL;
        ctrlView[hpcr_pkg::BIT_TO_HOST_INT] = toHostInt_r;
        ctrlView[hpcr_pkg::BIT_TO_CPU_INT] = toCpuInt_r;
        ctrlView[hpcr_pkg::BIT_HW_ORDER] = hwOrder_r;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hostCtrlRdata <= '0;
        end else if (hostCtrlRd) begin
            hostCtrlRdata <= ctrlView;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cpuRdata <= '0;
        end else if (cpuRe) begin
            // registered so the word stands until the next read strobe
            cpuRdata <= cpuReadMux;
        end
    end

    // ----------------------------------------------------------------
    // CPU read select
    // ----------------------------------------------------------------
    assign powerView = {30'h0000_0000, softHalt_r, freeRun_r};

    // unmapped offsets read zero
    always_comb begin
        case (cpuAddr)
            hpcr_pkg::OFF_POWER_EMU: begin
                cpuReadMux = powerView;
            end
            hpcr_pkg::OFF_PORT_CTRL: begin
                cpuReadMux = {16'h0000, ctrlView};
            end
            hpcr_pkg::OFF_WR_ADDR: begin
                cpuReadMux = writeAddr;
            end
            hpcr_pkg::OFF_RD_ADDR: begin
                cpuReadMux = readAddr;
            end
            default: begin
                cpuReadMux = 32'h0000_0000;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // address registers
    // ----------------------------------------------------------------
    hpcr_addr_route #(
        .AW(AW)
    ) u_addr (
        .sys_clk(sys_clk),
        .rst(rst),
        .splitMode(splitMode_r),
        .addrSelect(addrSelect_r),
        .halfwordOrder(hwOrder_r),
        .hostAddrWr(hostAddrWr),
        .hostAddrRd(hostAddrRd),
        .hostSecondHalf(hostSecondHalf),
        .hostWdata(hostAddrWdata),
        .hostAddrRdata(hostAddrRdata),
        .cpuWrAddrWe(cpuWrAddrWe),
        .cpuRdAddrWe(cpuRdAddrWe),
        .cpuWdata(cpuWdata),
        .writeAddr(writeAddr),
        .readAddr(readAddr)
    );
endmodule

/* verif/hpcr_regs_monitor.sv */
/*
 * Checker for the control register block, bound to hpcr_regs.
 * Assumes one clock sys_clk with synchronous active-high rst.
 */
`timescale 1ns/1ns
module hpcr_regs_monitor (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cpuWe,
    input wire logic [5:0] cpuAddr,
    input wire logic [31:0] cpuWdata,
    input wire logic hostCtrlWr,
    input wire logic [15:0] hostCtrlWdata,
    input wire logic emuSuspend,
    input wire logic xferBusy,
    input wire logic portHalted,
    input wire logic portSoftReset,
    input wire logic fetchRequest,
    input wire logic cpuIntPulse,
    input wire logic hostIntN,
    input wire logic halfwordOrder
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic cpuCtl;
    assign cpuCtl = cpuWe && (cpuAddr == hpcr_pkg::OFF_PORT_CTRL);

    a_to_host_interrupt_set: assert property (cpuCtl && cpuWdata[2] |=> !hostIntN)
        else $error("host interrupt not raised");
    a_to_host_interrupt_clear: assert property (hostCtrlWr && hostCtrlWdata[2]
        && !(cpuCtl && cpuWdata[2]) |=> hostIntN)
        else $error("host interrupt not cleared");
    a_to_host_interrupt_hold: assert property (!hostIntN && !hostCtrlWr |=> !hostIntN)
        else $error("host interrupt dropped alone");
    a_fetch_pulse: assert property (hostCtrlWr && hostCtrlWdata[4] |=> fetchRequest)
        else $error("fetch request missing");
    a_cpuint_cause: assert property (cpuIntPulse |-> $past(hostCtrlWr && hostCtrlWdata[1]))
        else $error("spurious cpu interrupt");
    a_order_track: assert property (hostCtrlWr |=> halfwordOrder == $past(hostCtrlWdata[0]))
        else $error("halfword order not written");
    a_srst_cpu: assert property (cpuCtl && !hostCtrlWr
        |=> portSoftReset == $past(cpuWdata[7]))
        else $error("software reset write lost");
    a_srst_hold: assert property (!cpuCtl && !hostCtrlWr |=> $stable(portSoftReset))
        else $error("software reset changed alone");
    a_halt_rise: assert property ($rose(portHalted) |-> $past(emuSuspend && !xferBusy))
        else $error("halt before transfer end");
    a_halt_need: assert property (portHalted |-> $past(emuSuspend))
        else $error("halt without suspend");

    c_halt: cover property ($rose(portHalted));
    c_to_host_interrupt: cover property ($fell(hostIntN));
    c_fetch: cover property (fetchRequest);
    c_collide: cover property (hostCtrlWr && cpuCtl);
endmodule

/* verif/hpcr_host_model.sv */
/*
 * Behavioural host: forwards bench commands onto the control port and
 * acknowledges the host interrupt once it has been low for more than ackWait cycles when autoAck is set.
 * Assumes bench commands change 1 ns after the rising edge.
 */
`timescale 1ns/1ns
module hpcr_host_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hostIntN,
    input wire logic cmdWr,
    input wire logic cmdRd,
    input wire logic [15:0] cmdData,
    input wire logic autoAck,
    input wire logic [3:0] ackWait,
    output logic hostCtrlWr,
    output logic hostCtrlRd,
    output logic [15:0] hostCtrlWdata
);
    logic [3:0] waitCnt = 4'h0;
    logic ackNow;
    initial begin
        hostCtrlWr = 1'b0;
        hostCtrlRd = 1'b0;
        hostCtrlWdata = 16'h0000;
    end
    // commands are taken at the edge and driven 1 ns later, like the bench
    always @(posedge sys_clk) begin
        waitCnt = hostIntN ? 4'h0 : waitCnt + 4'h1;
        ackNow = autoAck && !rst && !hostIntN && waitCnt > ackWait && !cmdWr && !cmdRd;
        hostCtrlWr <= #1 cmdWr || ackNow;
        hostCtrlRd <= #1 cmdRd;
        // idle bus shows a changing pattern, never the last value
        hostCtrlWdata <= #1 ackNow ? 16'h0004 : (cmdWr ? cmdData : ~hostCtrlWdata);
    end
endmodule

/* verif/hpcr_regs_test.sv */
/*
 * Self-checking bench for hpcr_regs with a host model on the control port.
 * Assumes a 4 ns clock and inputs driven 1 ns after the rising edge.
 */
`timescale 1ns/1ns
module hpcr_regs_test;
    logic sysClk = 1'b0, rst = 1'b1, cpuWe = 1'b0, cpuRe = 1'b0, cmdWr = 1'b0, cmdRd = 1'b0;
    logic [5:0] cpuAddr = 6'h00;
    logic [31:0] cpuWdata = 32'h0, cpuRdata, writeAddr, readAddr;
    logic [15:0] cmdData = 16'h0, hostCtrlWdata, hostCtrlRdata, hostAddrWdata = 16'h0;
    logic [15:0] hostAddrRdata;
    logic hostAddrWr = 1'b0, hostAddrRd = 1'b0, hostSecondHalf = 1'b0, emuSuspend = 1'b0;
    logic xferBusy = 1'b0, autoAck = 1'b0, hostCtrlWr, hostCtrlRd, portHalted, portSoftReset;
    logic fetchRequest, cpuIntPulse, hostIntN, halfwordOrder, lastFetch, lastCpuInt;
    logic [3:0] ackWait = 4'h3;
    int nFail = 0, checkCount = 0;
    logic [1:0] modes [4] = '{2'h1, 2'h3, 2'h0, 2'h2};
    logic bootViaPort = 1'b0;

    always #2 sysClk = ~sysClk;

    hpcr_regs #(.AW(32)) DUT (.sys_clk(sysClk), .rst(rst), .bootViaPort(bootViaPort),
        .cpuWe(cpuWe), .cpuRe(cpuRe), .cpuAddr(cpuAddr), .cpuWdata(cpuWdata), .cpuRdata(cpuRdata),
        .hostCtrlWr(hostCtrlWr), .hostCtrlRd(hostCtrlRd), .hostCtrlWdata(hostCtrlWdata),
        .hostCtrlRdata(hostCtrlRdata), .hostAddrWr(hostAddrWr), .hostAddrRd(hostAddrRd),
        .hostSecondHalf(hostSecondHalf), .hostAddrWdata(hostAddrWdata),
        .hostAddrRdata(hostAddrRdata), .writeAddr(writeAddr), .readAddr(readAddr),
        .emuSuspend(emuSuspend), .xferBusy(xferBusy), .portHalted(portHalted),
        .portSoftReset(portSoftReset), .fetchRequest(fetchRequest), .cpuIntPulse(cpuIntPulse),
        .hostIntN(hostIntN), .halfwordOrder(halfwordOrder));

    hpcr_host_model HOST (.sys_clk(sysClk), .rst(rst), .hostIntN(hostIntN), .cmdWr(cmdWr),
        .cmdRd(cmdRd), .cmdData(cmdData), .autoAck(autoAck), .ackWait(ackWait),
        .hostCtrlWr(hostCtrlWr), .hostCtrlRd(hostCtrlRd), .hostCtrlWdata(hostCtrlWdata));

    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge sysClk);
        #1;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            nFail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cpuWr(input logic [5:0] a, input logic [31:0] d);
        tick(1); cpuWe = 1'b1; cpuAddr = a; cpuWdata = d;
        tick(1); cpuWe = 1'b0;
    endtask
    task automatic cpuRd(input logic [5:0] a, input logic [31:0] exp);
        tick(1); cpuRe = 1'b1; cpuAddr = a;
        tick(1); cpuRe = 1'b0;
        check(cpuRdata, exp);
    endtask
    task automatic hostWr(input logic [15:0] d);
        tick(1); cmdWr = 1'b1; cmdData = d;
        tick(1); cmdWr = 1'b0;
        tick(1); lastFetch = fetchRequest; lastCpuInt = cpuIntPulse;
    endtask
    task automatic hostRd(input logic [15:0] exp);
        tick(1); cmdRd = 1'b1;
        tick(1); cmdRd = 1'b0;
        tick(1); check({16'h0, hostCtrlRdata}, {16'h0, exp});
    endtask
    task automatic hostAr(input logic sec, input logic [15:0] exp);
        tick(1); hostAddrRd = 1'b1; hostSecondHalf = sec;
        tick(1); hostAddrRd = 1'b0;
        check({16'h0, hostAddrRdata}, {16'h0, exp});
    endtask
    task automatic hostAw(input logic sec, input logic [15:0] d);
        tick(1); hostAddrWr = 1'b1; hostSecondHalf = sec; hostAddrWdata = d;
        tick(1); hostAddrWr = 1'b0;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        cpuRd(hpcr_pkg::OFF_PORT_CTRL, 32'h0088);
        check({portSoftReset, hostIntN}, 2'h3);
        cpuRd(6'h00, 32'h0);
        cpuRd(hpcr_pkg::OFF_POWER_EMU, 32'h0);
        cpuWr(hpcr_pkg::OFF_PORT_CTRL, 32'h0000); tick(1);
        check(portSoftReset, 1'b0);
        hostRd(16'h0008);
        cpuWr(hpcr_pkg::OFF_PORT_CTRL, 32'h0080); tick(1);
        check(portSoftReset, 1'b1);
        cpuWr(hpcr_pkg::OFF_PORT_CTRL, 32'h0000); tick(1);
        check(portSoftReset, 1'b0);
        $display("reset test done");
    endtask
    task automatic t_ctrl;
        hostWr(16'h0a01); hostRd(16'h0b09);
        check(halfwordOrder, 1'b1);
        cpuWr(hpcr_pkg::OFF_PORT_CTRL, 32'h0000_0a01); cpuWr(hpcr_pkg::OFF_PORT_CTRL, 32'h0);
        cpuRd(hpcr_pkg::OFF_PORT_CTRL, 32'h0b09);
        hostWr(16'h0000); hostRd(16'h0008);
        $display("control test done");
    endtask
    task automatic t_ints;
        cpuWr(hpcr_pkg::OFF_PORT_CTRL, 32'h4); tick(1);
        check(hostIntN, 1'b0);
        hostWr(16'h0000); check(hostIntN, 1'b0);
        cpuRd(hpcr_pkg::OFF_PORT_CTRL, 32'h000c);
        autoAck = 1'b1;
        for (int i = 0; i < 20 && !hostIntN; i++) tick(1);
        autoAck = 1'b0;
        check(hostIntN, 1'b1);
        hostWr(16'h0012); check({lastFetch, lastCpuInt}, 2'h3);
        hostRd(16'h000a);
        hostWr(16'h0002); check(lastCpuInt, 1'b0);
        cpuWr(hpcr_pkg::OFF_PORT_CTRL, 32'h2); hostRd(16'h0008);
        cmdWr = 1'b1; cmdData = 16'h0002; tick(1);
        cmdWr = 1'b0; cpuWe = 1'b1; cpuAddr = hpcr_pkg::OFF_PORT_CTRL; cpuWdata = 32'h2; tick(1);
        cpuWe = 1'b0;
        cpuRd(hpcr_pkg::OFF_PORT_CTRL, 32'h000a);
        cpuWr(hpcr_pkg::OFF_PORT_CTRL, 32'h2); hostRd(16'h0008);
        $display("interrupt test done");
    endtask
    task automatic t_addr;
        hostAw(1'b0, 16'h1234); hostAw(1'b1, 16'h5678); tick(1);
        check(writeAddr, 32'h1234_5678); check(readAddr, 32'h1234_5678);
        hostWr(16'h0a01); hostAw(1'b0, 16'haaaa); hostAw(1'b1, 16'hbbbb); tick(1);
        check(readAddr, 32'hbbbb_aaaa); check(writeAddr, 32'h1234_5678);
        hostWr(16'h0200); hostAw(1'b0, 16'h1111); hostAw(1'b1, 16'h2222); tick(1);
        check(writeAddr, 32'h1111_2222); check(readAddr, 32'hbbbb_aaaa);
        hostAr(1'b0, 16'h1111);
        hostWr(16'h0000); cpuWr(hpcr_pkg::OFF_WR_ADDR, 32'h40); tick(1);
        check(writeAddr, 32'h40); check(readAddr, 32'hbbbb_aaaa);
        hostAr(1'b0, 16'hbbbb);
        hostAr(1'b1, 16'haaaa);
        $display("address test done");
    endtask
    task automatic t_emu;
        foreach (modes[i]) begin
            cpuWr(hpcr_pkg::OFF_POWER_EMU, {30'h0, modes[i]});
            cpuRd(hpcr_pkg::OFF_POWER_EMU, {30'h0, modes[i]});
            emuSuspend = 1'b1; xferBusy = 1'b1; tick(3);
            check(portHalted, 1'b0);
            xferBusy = 1'b0; tick(3);
            check(portHalted, modes[i] == 2'h2);
            emuSuspend = 1'b0; tick(3);
            check(portHalted, 1'b0);
        end
        $display("emulation test done");
    endtask
    task automatic t_boot;
        bootViaPort = 1'b1; rst = 1'b1; tick(20);
        rst = 1'b0;
        cpuRd(hpcr_pkg::OFF_PORT_CTRL, 32'h0008);
        check({portSoftReset, hostIntN}, 2'h1);
        $display("boot test done");
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", checkCount, nFail);
        if (nFail == 0 && checkCount > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        tick(20);
        rst = 1'b0;
        t_reset; t_ctrl; t_ints; t_addr; t_emu; t_boot;
        results;
    end
    initial begin
        #40000;
        nFail++;
        $display("watchdog expired");
        results;
    end
endmodule

bind hpcr_regs hpcr_regs_monitor MON (.sys_clk, .rst, .cpuWe, .cpuAddr, .cpuWdata, .hostCtrlWr,
    .hostCtrlWdata, .emuSuspend, .xferBusy, .portHalted, .portSoftReset, .fetchRequest,
    .cpuIntPulse, .hostIntN, .halfwordOrder);
